// ### verilog/cbt_pkg.sv
// Operation
// (RULE1) Strobe held low/high before clock-enable drops
// (RULE2) Too-fast samples dropped; last echoed after delay
// (RULE3) Exit delay sized from reference range bit
// (RULE4) Mode 1: lower seven data pins only output
// (RULE5) Mode 2: eighth data pin sets direction
// (RULE6) Controller writes zero to training-mode select
// (RULE7) Power-up uses operating set zero
// (RULE8) Controller programs write set one first
// (RULE9) Clock-enable low swaps to alternate set
// (RULE10) Clock-enable high reverts set, drops training
// (RULE11) Two mode writes set training enable
// (RULE12) Clock-enable low after mode-set delay
// (RULE13) Patterns accepted after training-entry delay
// (RULE14) Latched command bits echoed onto data bus
// (RULE15) Termination follows active set, except outputs
// (RULE16) Exit: enable high, wait, clear enable
// (RULE17) Start from idle or non-powered-down self refresh
// (RULE18) Terminating rank trained before others
// (RULE19) Fast clock only while enable is low
// (RULE20) Alternate programming and comparing phases
// (RULE21) Echo may sit on upper byte pins
// (RULE22) Command bit n echoed on data pin n
// (RULE23) Passing result applied by switching active set
package cbt_pkg;
	localparam int CLK_MHZ = 50;
	// Link timing, figures in ns
	localparam int ASYNC_READ_NS = 20;
	localparam int STROBE_HOLD_NS = 10;
	localparam int ENTRY_NS = 250;
	localparam int EXIT_SHORT_NS = 200;
	localparam int EXIT_LONG_NS = 250;
	// Longest time rounds down, least times round up
	localparam logic [7:0] ASYNC_READ_CYC = 8'((ASYNC_READ_NS * CLK_MHZ) / 1000);
	localparam logic [7:0] STROBE_HOLD_CYC = 8'((STROBE_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ENTRY_CYC = 8'((ENTRY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] EXIT_SHORT_CYC = 8'((EXIT_SHORT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] EXIT_LONG_CYC = 8'((EXIT_LONG_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] MODE_SET_CYC = 8'h10;
	localparam logic [7:0] MODE_WRITE_CYC = 8'h10;
	// Controller margins cover the two-flop input stages of both ends
	localparam logic [7:0] SYNC_MARGIN_CYC = 8'h08;
	localparam logic [7:0] CAPT_CYC = 8'h10;
	localparam logic [7:0] SETTLE_CYC = 8'h10;
	// Link clock half periods in pclk cycles
	localparam logic [2:0] HALF_SLOW = 3'h4;
	localparam logic [2:0] HALF_FAST = 3'h2;
	// Mode write framing on the command bus
	localparam logic [4:0] MRW1_CODE = 5'h06;
	localparam logic [4:0] MRW2_CODE = 5'h16;
	// Mode register addresses on the link
	localparam logic [5:0] TERM_ADDR = 6'h0B;
	localparam logic [5:0] VREF_ADDR = 6'h0C;
	localparam logic [5:0] SETPT_ADDR = 6'h0D;
	localparam logic [5:0] MODE_ADDR = 6'h29;
	// Setpoint control fields
	localparam int SP_TRAIN_BIT = 0;
	localparam int SP_WR_BIT = 6;
	localparam int SP_OP_BIT = 7;
	localparam logic [7:0] SETPT_PREP = 8'h40;
	localparam logic [7:0] SETPT_ENTER = 8'h41;
	localparam logic [7:0] SETPT_USE1 = 8'hC0;
	localparam logic [7:0] TERM_ON = 8'h01;
	localparam logic [7:0] MODE1_SEL = 8'h00;
	// Controller APB map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] VREF_OFS = 8'h04;
	localparam logic [7:0] PAT_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_APPLY_BIT = 1;
	localparam int CTRL_DQ7_BIT = 2;
	typedef enum logic [2:0] {DV_NORM = 3'b001, DV_ENTRY = 3'b010, DV_TRAIN = 3'b100} cbt_dev_e;
	typedef enum logic [3:0] {CT_IDLE = 4'b0001, CT_STEP = 4'b0010, CT_LINK = 4'b0100,
		CT_WAIT = 4'b1000} cbt_ctl_e;
	typedef enum logic [2:0] {OP_MRW, OP_WAIT, OP_CKELO, OP_SEND, OP_CKEHI, OP_APPLY,
		OP_END} cbt_op_e;
endpackage

// ### verilog/cbt_if.sv
`timescale 1ns/1ns
`default_nettype none
// Command bus training link between controller and memory die
interface cbt_if;
	logic ck;
	logic cke;
	logic cs;
	logic [5:0] ca;
	logic [15:0] dq_o;
	logic [15:0] dq_oe;
	logic dq7_o;
	logic dq7_oe;
	logic dqs_t_o;
	logic dqs_t_oe;
	logic dqs_c_o;
	logic dqs_c_oe;
	modport dev (input ck, cke, cs, ca, dq7_o, dq7_oe, output dq_o, dq_oe);
	modport ctl (output ck, cke, cs, ca, dq7_o, dq7_oe, dqs_t_o, dqs_t_oe, dqs_c_o, dqs_c_oe,
		input dq_o, dq_oe);
endinterface
`default_nettype wire

// ### verilog/cbt_dev.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_dev
	import cbt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	cbt_if.dev link,
	input wire logic byte_swap,
	output logic training_active,
	output logic active_set,
	output logic [6:0] vref_active,
	output logic [15:0] term_on,
	output logic train_mode
);
	typedef struct packed {
		logic [9:0] s1;
		logic [9:0] s2;
		logic ck_d;
		cbt_dev_e st;
		logic [7:0] cnt;
		logic [1:0] pend;
		logic [5:0] addr;
		logic [1:0] hi;
		logic set_op;
		logic set_wr;
		logic tr_en;
		logic mode;
		logic [1:0][6:0] vref;
		logic [1:0] term;
		logic [5:0] smp;
		logic [7:0] rd_cnt;
		logic rd_busy;
		logic [5:0] echo;
		logic echo_v;
		logic swap;
		logic strap_done;
	} cbt_dev_s;

	cbt_dev_s r;
	cbt_dev_s n;
	logic ck_s;
	logic cke_s;
	logic cs_s;
	logic [5:0] ca_s;
	logic dq7_s;
	logic rise;
	logic eff;
	logic oe;
	logic [7:0] d;
	logic [6:0] lane;

	// Second-stage samples only; the first stage feeds nothing else
	assign ck_s = r.s2[9];
	assign cke_s = r.s2[8];
	assign cs_s = r.s2[7];
	assign ca_s = r.s2[6:1];
	assign dq7_s = r.s2[0];
	assign rise = ck_s & ~r.ck_d;
	assign d = {r.hi, ca_s};
	assign eff = r.set_op ^ (r.st != DV_NORM); // see (RULE9) (RULE10)
	assign oe = (r.st == DV_TRAIN) & (~r.mode | dq7_s); // see (RULE4) (RULE5)

	// Next-state logic
	always_comb
	begin
		n = r;
		n.s1 = {link.ck, link.cke, link.cs, link.ca, link.dq7_oe & link.dq7_o};
		n.s2 = r.s1;
		n.ck_d = ck_s;
		// Strap caught once after reset release
		if (!r.strap_done)
		begin
			n.swap = byte_swap;
			n.strap_done = 1'b1;
		end
		// Echo timer; a new sample restarts it, so skipped samples never show
		if (r.rd_busy)
		begin
			if (r.rd_cnt >= ASYNC_READ_CYC - 8'h01)
			begin
				n.echo = r.smp; // see (RULE14) (RULE2)
				n.echo_v = 1'b1;
				n.rd_busy = 1'b0;
			end
			else
				n.rd_cnt = r.rd_cnt + 8'h01;
		end
		case (r.st)
			DV_NORM:
			begin
				if (rise)
				begin
					if (cs_s)
					begin
						n.pend = 2'h0;
						if (ca_s[4:0] == MRW1_CODE)
						begin
							n.pend = 2'h1;
							n.hi[1] = ca_s[5];
						end
						else if (ca_s[4:0] == MRW2_CODE && r.pend == 2'h0)
						begin
							n.pend = 2'h2;
							n.hi[0] = ca_s[5];
						end
					end
					else if (r.pend == 2'h1)
					begin
						n.addr = ca_s;
						n.pend = 2'h0;
					end
					else if (r.pend == 2'h2)
					begin
						n.pend = 2'h0;
						// Set data goes to the set chosen for writing
						case (r.addr)
							SETPT_ADDR:
							begin
								n.tr_en = d[SP_TRAIN_BIT];
								n.set_wr = d[SP_WR_BIT];
								n.set_op = d[SP_OP_BIT];
							end
							VREF_ADDR: n.vref[r.set_wr] = d[6:0];
							TERM_ADDR: n.term[r.set_wr] = d[0];
							MODE_ADDR: n.mode = d[0];
							default: ;
						endcase
					end
				end
				if (r.tr_en && !cke_s)
				begin
					n.st = DV_ENTRY; // see (RULE9)
					n.cnt = 8'h00;
					n.pend = 2'h0;
				end
			end
			DV_ENTRY:
			begin
				if (r.cnt >= ENTRY_CYC)
					n.st = DV_TRAIN; // see (RULE13)
				else
					n.cnt = r.cnt + 8'h01;
			end
			DV_TRAIN:
			begin
				if (rise && cs_s)
				begin
					n.smp = ca_s; // see (RULE22)
					n.rd_cnt = 8'h00;
					n.rd_busy = 1'b1;
					n.echo_v = 1'b0; // see (RULE2)
				end
			end
			default: n.st = DV_NORM;
		endcase
		// Clock-enable high ends the session; trained set values are kept, only the active set reverts
		if (r.st != DV_NORM && cke_s)
		begin
			n.st = DV_NORM; // see (RULE10)
			n.rd_busy = 1'b0;
			n.echo_v = 1'b0;
		end
	end

	// State register; reset lands on operating set zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '{st: DV_NORM, default: '0}; // see (RULE7)
		else
			r <= n;
	end

	// Echo lane placement depends on the package strap
	assign lane = {1'b0, r.echo_v ? r.echo : 6'h00};
	assign link.dq_o = r.swap ? {1'b0, lane, 8'h00} : {9'h000, lane}; // see (RULE21)
	assign link.dq_oe = r.swap ? {1'b0, {7{oe}}, 8'h00} : {9'h000, {7{oe}}};
	assign term_on = {16{r.term[eff]}} & ~link.dq_oe; // see (RULE15)
	assign training_active = (r.st != DV_NORM);
	assign active_set = eff;
	assign vref_active = r.vref[eff];
	assign train_mode = r.mode;
endmodule
`default_nettype wire

// ### verilog/cbt_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_ctl
	import cbt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	cbt_if.ctl link
);
	typedef struct packed {
		cbt_op_e k;
		logic [5:0] a;
		logic [7:0] d;
		logic [7:0] w;
	} cbt_op_s;

	typedef struct packed {
		cbt_ctl_e st;
		logic [3:0] seq;
		logic [7:0] cnt;
		logic [2:0] beat;
		logic [2:0] div;
		logic ck;
		logic fast;
		logic cke;
		logic cs;
		logic [5:0] ca;
		logic dqs_drv;
		logic apply;
		logic dq7;
		logic [6:0] vref;
		logic [5:0] pat;
		logic done;
		logic match;
		logic [5:0] echo;
		logic [5:0] s1;
		logic [5:0] s2;
		logic [31:0] rdata;
		logic err;
	} cbt_ctl_s;

	cbt_ctl_s r;
	cbt_ctl_s n;
	cbt_op_s op;
	logic [2:0] half;
	logic wrap;
	logic tick;
	logic wr;
	logic [15:0] dq_v;

	// Fixed training script; one entry per step
	function automatic cbt_op_s op_at(input logic [3:0] i, input logic [6:0] v,
		input logic go);
		cbt_op_s o;
		o = '{k: OP_WAIT, a: 6'h00, d: 8'h00, w: 8'h00};
		case (i)
			4'h0: o = '{k: OP_MRW, a: SETPT_ADDR, d: SETPT_PREP, w: 8'h00}; // see (RULE8)
			4'h1: o = '{k: OP_MRW, a: VREF_ADDR, d: {1'b0, v}, w: 8'h00}; // see (RULE8)
			// Single rank: this die is the terminating rank, so it is trained first
			4'h2: o = '{k: OP_MRW, a: TERM_ADDR, d: TERM_ON, w: 8'h00}; // see (RULE18)
			4'h3: o = '{k: OP_MRW, a: MODE_ADDR, d: MODE1_SEL, w: 8'h00}; // see (RULE6)
			4'h4: o = '{k: OP_MRW, a: SETPT_ADDR, d: SETPT_ENTER, w: 8'h00}; // see (RULE11)
			4'h5: o.w = MODE_SET_CYC; // see (RULE12)
			4'h6: o = '{k: OP_CKELO, a: 6'h00, d: 8'h00, w: STROBE_HOLD_CYC}; // see (RULE1)
			4'h7: o.w = ENTRY_CYC + SYNC_MARGIN_CYC;
			4'h8: o = '{k: OP_SEND, a: 6'h00, d: 8'h00, w: 8'h00};
			4'h9: o.w = CAPT_CYC;
			4'hA: o = '{k: OP_CKEHI, a: 6'h00, d: 8'h00, w: SETTLE_CYC}; // see (RULE19)
			4'hB: o.w = v[6] ? EXIT_LONG_CYC : EXIT_SHORT_CYC; // see (RULE3) (RULE16)
			4'hC: o = '{k: OP_MRW, a: SETPT_ADDR, d: SETPT_PREP, w: 8'h00}; // see (RULE16)
			4'hD: o.w = MODE_WRITE_CYC;
			4'hE: o = '{k: go ? OP_APPLY : OP_WAIT, a: SETPT_ADDR, d: SETPT_USE1,
				w: 8'h00}; // see (RULE23)
			default: o.k = OP_END;
		endcase
		return o;
	endfunction

	// Link clock divider; command changes land on its falling edge
	assign half = r.fast ? HALF_FAST : HALF_SLOW;
	assign wrap = (r.div >= half - 3'h1);
	assign tick = wrap & r.ck;
	assign op = op_at(r.seq, r.vref, r.apply & r.match);
	assign wr = psel & penable & pwrite;
	assign dq_v = link.dq_o & link.dq_oe;

	// Next-state logic
	always_comb
	begin
		n = r;
		n.div = wrap ? 3'h0 : r.div + 3'h1;
		if (wrap)
			n.ck = ~r.ck;
		// Either echo lane, so both package strap settings work
		n.s1 = dq_v[5:0] | dq_v[13:8];
		n.s2 = r.s1;
		// Read data and error prepared in the setup phase
		if (psel && !penable)
		begin
			n.err = 1'b0;
			case (paddr)
				CTRL_OFS: n.rdata = {29'h0, r.dq7, r.apply, 1'b0};
				VREF_OFS: n.rdata = {25'h0, r.vref};
				PAT_OFS: n.rdata = {26'h0, r.pat};
				STAT_OFS: n.rdata = {18'h0, r.echo, 5'h0, r.match, r.done, r.st != CT_IDLE};
				default:
				begin
					n.rdata = 32'h0;
					n.err = 1'b1;
				end
			endcase
		end
		if (wr)
		begin
			case (paddr)
				CTRL_OFS:
				begin
					n.apply = pwdata[CTRL_APPLY_BIT];
					n.dq7 = pwdata[CTRL_DQ7_BIT];
					// Start is ignored while a run is underway
					if (pwdata[CTRL_START_BIT] && r.st == CT_IDLE)
					begin
						n.st = CT_STEP;
						n.seq = 4'h0;
						n.done = 1'b0;
						n.match = 1'b0;
					end
				end
				VREF_OFS: n.vref = pwdata[6:0];
				PAT_OFS: n.pat = pwdata[5:0];
				default: ;
			endcase
		end
		case (r.st)
			CT_IDLE: ;
			CT_STEP:
			begin
				n.cnt = 8'h00;
				n.beat = 3'h0;
				case (op.k)
					OP_MRW, OP_SEND, OP_APPLY: n.st = CT_LINK;
					OP_WAIT: n.st = CT_WAIT;
					OP_CKELO:
					begin
						n.dqs_drv = 1'b1; // see (RULE1)
						n.st = CT_WAIT;
					end
					OP_CKEHI:
					begin
						// Compare and slow the clock in the same cycle, before raising enable
						n.echo = r.s2;
						n.match = (r.s2 == r.pat); // see (RULE20)
						n.fast = 1'b0; // see (RULE19)
						n.st = CT_WAIT;
					end
					default:
					begin
						n.st = CT_IDLE;
						n.done = 1'b1;
					end
				endcase
			end
			CT_LINK:
			begin
				// Beats advance on the link clock's falling edge
				if (tick)
				begin
					n.beat = r.beat + 3'h1;
					n.cs = 1'b0;
					n.ca = 6'h00;
					case (r.beat)
						3'h0:
						begin
							n.cs = 1'b1;
							n.ca = (op.k == OP_SEND) ? r.pat : {op.d[7], MRW1_CODE};
						end
						3'h1: n.ca = (op.k == OP_SEND) ? 6'h00 : op.a;
						3'h2: n.cs = (op.k != OP_SEND);
						3'h3: n.ca = op.d[5:0];
						default: ;
					endcase
					if (r.beat == 3'h2)
						n.ca = {op.d[6], MRW2_CODE};
					if ((op.k == OP_SEND && r.beat == 3'h1) || r.beat == 3'h4)
					begin
						n.st = CT_STEP;
						n.seq = r.seq + 4'h1;
					end
				end
			end
			CT_WAIT:
			begin
				if (r.cnt >= op.w)
				begin
					n.st = CT_STEP;
					n.seq = r.seq + 4'h1;
					if (op.k == OP_CKELO)
					begin
						n.cke = 1'b0; // see (RULE12) (RULE17)
						n.fast = 1'b1; // see (RULE19)
					end
					if (op.k == OP_CKEHI)
					begin
						n.cke = 1'b1; // see (RULE16)
						n.dqs_drv = 1'b0;
					end
				end
				else
					n.cnt = r.cnt + 8'h01;
			end
			default: n.st = CT_IDLE;
		endcase
	end

	// State register; enable starts high so the die is never powered down
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '{st: CT_IDLE, cke: 1'b1, default: '0};
		else
			r <= n;
	end

	// Link and bus outputs
	assign link.ck = r.ck;
	assign link.cke = r.cke;
	assign link.cs = r.cs;
	assign link.ca = r.ca;
	assign link.dq7_o = r.dq7;
	assign link.dq7_oe = r.dq7;
	assign link.dqs_t_o = 1'b0; // see (RULE1)
	assign link.dqs_t_oe = r.dqs_drv;
	assign link.dqs_c_o = 1'b1;
	assign link.dqs_c_oe = r.dqs_drv;
	assign prdata = r.rdata;
	assign pready = 1'b1;
	assign pslverr = r.err;
endmodule
`default_nettype wire

// ### verilog/cbt_ctl_fix_note.sv
`timescale 1ns/1ns

// ### testbench/cbt_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_asserts
	import cbt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ck,
	input wire logic cke,
	input wire logic cs,
	input wire logic [5:0] ca,
	input wire logic [15:0] dq_o,
	input wire logic [15:0] dq_oe,
	input wire logic dqs_t_o,
	input wire logic dqs_t_oe,
	input wire logic dqs_c_o,
	input wire logic dqs_c_oe
);
	logic [7:0] low_cnt;
	logic [7:0] high_cnt;
	logic [7:0] quiet_cnt;
	logic [5:0] ca_seen;
	logic echo_ok;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Saturating counters give time since each link event; saturation avoids wrap-around
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_cnt <= 8'h00;
			high_cnt <= 8'hFF;
			quiet_cnt <= 8'hFF;
			ca_seen <= 6'h00;
		end
		else
		begin
			low_cnt <= cke ? 8'h00 : ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01);
			high_cnt <= !cke ? 8'h00 : ((high_cnt == 8'hFF) ? high_cnt : high_cnt + 8'h01);
			quiet_cnt <= cs ? 8'h00 : ((quiet_cnt == 8'hFF) ? quiet_cnt : quiet_cnt + 8'h01);
			if ($rose(ck) && cs && !cke)
				ca_seen <= ca;
		end
	end
	// Either byte lane may carry the echo, depending on the strap
	assign echo_ok = (dq_oe[6:0] == 7'h7F && dq_o[6:0] == {1'b0, ca_seen})
		|| (dq_oe[14:8] == 7'h7F && dq_o[14:8] == {1'b0, ca_seen});
	AST_STROBE_HOLD: assert property ($fell(cke) |-> dqs_t_oe && !dqs_t_o && dqs_c_oe && dqs_c_o
		&& $past(dqs_t_oe) && $past(dqs_c_oe)) else $error("strobe pair not parked at entry");
	AST_LOWER_LANES: assert property ((dq_oe != 16'h0000) |->
		(dq_oe == 16'h007F || dq_oe == 16'h7F00)) else $error("echo lanes wrong");
	AST_ENTRY_DELAY: assert property ($rose(dq_oe != 16'h0000) |->
		!cke && low_cnt >= ENTRY_CYC) else $error("echo driven before entry delay");
	AST_EXIT_RELEASE: assert property ($rose(cke) |-> ##[1:8] (dq_oe == 16'h0000))
		else $error("data pins still driven after exit");
	AST_ECHO: assert property ($rose(ck) && cs && !cke |-> ##[2:12] echo_ok)
		else $error("sample not echoed");
	AST_EXIT_GAP: assert property (cs && cke |-> high_cnt >= EXIT_SHORT_CYC)
		else $error("command too soon after exit");
	AST_MODE_SET: assert property ($fell(cke) |-> quiet_cnt >= MODE_SET_CYC)
		else $error("clock enable fell before mode-set delay");
	AST_SLOW_CLOCK: assert property (cke [*4] ##0 $changed(ck) |->
		$past(ck, 3) == $past(ck, 1)) else $error("fast link clock outside training");
	// Main scenarios reached
	cover property ($fell(cke));
	cover property ($rose(ck) && cs && !cke);
	cover property ($rose(cke) ##[1:8] (dq_oe == 16'h0000));
endmodule
`default_nettype wire

// ### testbench/command_bus_training_byte_mode_tb.sv
`timescale 1ns/1ns
`default_nettype none
module command_bus_training_byte_mode_tb
	import cbt_pkg::*;
;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic byte_swap;
	logic training_active;
	logic active_set;
	logic [6:0] vref_active;
	logic [15:0] term_on;
	logic train_mode;
	int num_errors;
	int checks;
	cbt_if i_cbt_if();
	cbt_ctl i_cbt_ctl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(i_cbt_if));
	cbt_dev i_cbt_dev(.pclk(pclk), .presetn(presetn), .link(i_cbt_if), .byte_swap(byte_swap),
		.training_active(training_active), .active_set(active_set), .vref_active(vref_active),
		.term_on(term_on), .train_mode(train_mode));
	cbt_asserts i_cbt_asserts(.pclk(pclk), .presetn(presetn), .ck(i_cbt_if.ck),
		.cke(i_cbt_if.cke), .cs(i_cbt_if.cs), .ca(i_cbt_if.ca), .dq_o(i_cbt_if.dq_o),
		.dq_oe(i_cbt_if.dq_oe), .dqs_t_o(i_cbt_if.dqs_t_o), .dqs_t_oe(i_cbt_if.dqs_t_oe),
		.dqs_c_o(i_cbt_if.dqs_c_o), .dqs_c_oe(i_cbt_if.dqs_c_oe));
	// Free-running 50 MHz clock
	always #10 pclk = ~pclk;
	task automatic complete_run();
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic expect_val(input logic [31:0] got, input logic [31:0] want, input string what);
		checks++;
		if (got !== want)
		begin
			$display("unexpected at %0t: %s", $time, what);
			num_errors++;
		end
	endtask
	// One APB transfer; the request is held until pready is seen high
	task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		expect_val(n < 100, 1, "apb answer missing");
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// Reset state and refused access
	task automatic check_reset();
		logic [31:0] r;
		logic e;
		expect_val(active_set, 0, "set after reset");
		expect_val(vref_active, 0, "vref after reset");
		expect_val(training_active, 0, "training after reset");
		apb_xfer(1'b0, STAT_OFS, 32'h0, r, e);
		expect_val(r, 0, "status after reset");
		expect_val({31'h0, e}, 0, "status error flag");
		apb_xfer(1'b0, 8'h10, 32'h0, r, e);
		expect_val(r, 0, "unmapped read data");
		expect_val({31'h0, e}, 1, "unmapped read error flag");
		// Control word reads back; the eighth data pin level has no effect in mode 1
		apb_xfer(1'b1, CTRL_OFS, 32'h1 << CTRL_DQ7_BIT, r, e);
		apb_xfer(1'b0, CTRL_OFS, 32'h0, r, e);
		expect_val(r, 32'h1 << CTRL_DQ7_BIT, "control readback");
		expect_val(training_active, 0, "no run without start");
	endtask
	// Full training pass: entry swap, echo lanes, termination, exit and optional apply
	task automatic run_train(input logic [6:0] vref, input logic [5:0] pat, input logic apply);
		logic [31:0] r;
		logic e;
		logic [15:0] lanes;
		int n;
		lanes = byte_swap ? 16'h7F00 : 16'h007F;
		apb_xfer(1'b1, VREF_OFS, {25'h0, vref}, r, e);
		apb_xfer(1'b1, PAT_OFS, {26'h0, pat}, r, e);
		apb_xfer(1'b1, CTRL_OFS, {30'h0, apply, 1'b1}, r, e);
		n = 0;
		while (i_cbt_if.dq_oe === 16'h0000 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		expect_val(active_set, 1, "alternate set in training");
		expect_val(vref_active, vref, "trained vref in use");
		expect_val(i_cbt_if.dq_oe, lanes, "echo lanes");
		expect_val(term_on, 16'(~lanes), "termination in training");
		n = 0;
		do
		begin
			apb_xfer(1'b0, STAT_OFS, 32'h0, r, e);
			n++;
		end
		while (r[1] !== 1'b1 && n < 500);
		expect_val(r[2], 1, "pattern match");
		expect_val(r[13:8], pat, "captured echo");
		expect_val(active_set, apply, "set after exit");
		expect_val(vref_active, apply ? vref : 7'h00, "vref after exit");
		expect_val(training_active, 0, "training left");
		expect_val(i_cbt_if.dq_oe, 0, "data pins released");
		expect_val(train_mode, 0, "mode 1 selected");
	endtask
	// Watchdog well beyond four training passes
	initial
	begin
		repeat (40000) @(posedge pclk);
		num_errors++;
		complete_run();
	end
	// Main sequence: both straps, range bit set once, apply on the last pass
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		byte_swap = 1'b0;
		num_errors = 0;
		checks = 0;
		do_reset();
		@(posedge pclk);
		check_reset();
		run_train(7'h12, 6'h2A, 1'b0);
		run_train(7'h55, 6'h15, 1'b0);
		byte_swap <= 1'b1;
		do_reset();
		@(posedge pclk);
		run_train(7'h0C, 6'h3F, 1'b0);
		run_train(7'h21, 6'h00, 1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
